// [hw/explicit_request_responder.sv]
/*
 * explicit register request responder: decodes unit and function code and
 * answers no earlier than the minimum response time.
 * assumes requests synchronous to clk; register data moves elsewhere.
 */
`timescale 1ns/10ps
module explicit_request_responder #(
    parameter int unsigned RESP_CYCLES = island_dispatch_pkg::RESP_CYCLES
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // request
    input  wire logic       reqValid,
    output logic            reqReady,
    input  wire logic [7:0] reqUnit,
    input  wire logic [7:0] reqFunc,
    // response
    output logic            rspValid,
    output logic            rspAccept,
    output logic [7:0]      rspException
);
    localparam int CNT_W = $clog2(RESP_CYCLES + 1);

    logic             busy_r;
    logic [CNT_W-1:0] waitCnt_r;
    logic             accept_r;
    logic             reqTake;
    logic             unitSelf;
    logic             funcOk;
    logic             waitDone;

    // both unit identifiers address this interface itself
    assign unitSelf = (reqUnit == island_dispatch_pkg::UNIT_SELF_HIGH) ||
                      (reqUnit == island_dispatch_pkg::UNIT_SELF_ZERO);
    assign funcOk   = (reqFunc == island_dispatch_pkg::FC_READ_MULTI) ||
                      (reqFunc == island_dispatch_pkg::FC_WRITE_MULTI) ||
                      (reqFunc == island_dispatch_pkg::FC_READ_WRITE);
    assign reqReady = !busy_r;
    assign reqTake  = reqValid && reqReady && unitSelf;
    assign waitDone = busy_r && (waitCnt_r == CNT_W'(RESP_CYCLES - 1));

    // ------------------------------------------------------------
    // response pacing
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            busy_r    <= 1'b0;
            waitCnt_r <= '0;
            accept_r  <= 1'b0;
        end
        else if (reqTake)
        begin
            busy_r    <= 1'b1;
            waitCnt_r <= '0;
            accept_r  <= funcOk;
        end
        else if (waitDone)
        begin
            busy_r <= 1'b0;
        end
        else if (busy_r)
        begin
            waitCnt_r <= waitCnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rspValid     <= 1'b0;
            rspAccept    <= 1'b0;
            rspException <= island_dispatch_pkg::EXC_NONE;
        end
        else
        begin
            rspValid <= waitDone;
            if (waitDone)
            begin
                rspAccept    <= accept_r;
                rspException <= accept_r ? island_dispatch_pkg::EXC_NONE
                                         : island_dispatch_pkg::EXC_ILLEGAL_FN;
            end
        end
    end

    sequence reqTakenSeq;
        reqValid && reqReady && unitSelf;
    endsequence

    AST_RESP_NOT_EARLY: assert property (@(posedge clk) disable iff (rst)
        rspValid |-> $past(waitCnt_r) == CNT_W'(RESP_CYCLES - 1))
        else $error("response given before the minimum time");
    AST_FUNC_ACCEPT: assert property (@(posedge clk) disable iff (rst)
        reqTakenSeq ##0 (reqFunc == island_dispatch_pkg::FC_READ_MULTI) |=> accept_r)
        else $error("read multiple registers refused");
    AST_FUNC_COMBINED: assert property (@(posedge clk) disable iff (rst)
        reqTakenSeq ##0 (reqFunc == island_dispatch_pkg::FC_READ_WRITE) |=> accept_r)
        else $error("combined read write refused");
    AST_UNIT_SELF: assert property (@(posedge clk) disable iff (rst)
        reqValid && reqReady && (reqUnit == island_dispatch_pkg::UNIT_SELF_ZERO) |=> busy_r)
        else $error("unit zero not taken as self");
endmodule

// [hw/island_output_image_dispatch.sv]
/*
 * output image store and dispatcher: assemblies from the scanner are kept per
 * assembly, module slots are checked at configuration, and module data goes
 * to the island bus once the image is complete and again on each update.
 * assumes byte writes synchronous to clk and an island bus with valid/ready.
 */
`timescale 1ns/10ps
//------------------------------------------------------------
// Contract
// - image opens with one island command register
// - discrete output module takes one register
// - analog output module takes two registers
// - module image stays inside one assembly
// - fieldbus device data totals 1024 bytes max
// - one fieldbus device: 250 bytes, one assembly
// - channel value low byte first, high next
// - first command waits for all assemblies; code waits only for assembly 0 and assemblies holding a configured module
// - module refreshed only after its assembly updates
// - fieldbus device refreshed after its assembly updates
// - accept read and write multiple registers
// - accept combined read and write registers
// - explicit response no sooner than 200 ms
// - unit 255 or 0 addresses the interface
//------------------------------------------------------------
module island_output_image_dispatch #(
    parameter int NUM_ASM = 2,
    parameter int OFF_W   = 9,
    parameter int NUM_MOD = 8,
    parameter int unsigned RESP_CYCLES = island_dispatch_pkg::RESP_CYCLES,
    // derived widths, declared here so the port list can use them
    localparam int ASM_W = (NUM_ASM > 1) ? $clog2(NUM_ASM) : 1,
    localparam int MOD_W = (NUM_MOD > 1) ? $clog2(NUM_MOD) : 1
) (
    // clock and reset
    input  wire logic                                clk,
    input  wire logic                                rst,
    // scanner assembly writes
    input  wire logic [NUM_ASM-1:0]                  connOpen,
    input  wire logic                                rxValid,
    input  wire logic [ASM_W-1:0]                    rxAsm,
    input  wire logic [OFF_W-1:0]                    rxOffset,
    input  wire logic [7:0]                          rxData,
    input  wire logic                                rxEnd,
    // module slot configuration
    input  wire logic                                cfgWrite,
    input  wire logic [MOD_W-1:0]                    cfgIndex,
    input  wire island_dispatch_pkg::module_kind_type cfgKind,
    input  wire logic [ASM_W-1:0]                    cfgAsm,
    input  wire logic [OFF_W-1:0]                    cfgOffset,
    input  wire logic [7:0]                          cfgLen,
    output logic                                     cfgError,
    output logic [11:0]                              fbTotal,
    // island bus
    output logic                                     islStarted,
    output logic                                     islCommandValid,
    output logic [15:0]                              islCommand,
    output logic                                     islValid,
    input  wire logic                                islReady,
    output logic [MOD_W-1:0]                         islModule,
    output logic [7:0]                               islData,
    output logic                                     islLast,
    // explicit requests
    input  wire logic                                reqValid,
    output logic                                     reqReady,
    input  wire logic [7:0]                          reqUnit,
    input  wire logic [7:0]                          reqFunc,
    output logic                                     rspValid,
    output logic                                     rspAccept,
    output logic [7:0]                               rspException
);
    localparam int ASM_BYTES = 1 << OFF_W;

    typedef enum logic {ST_IDLE, ST_SEND} disp_state_type;

    logic [7:0] image [NUM_ASM * ASM_BYTES];
    island_dispatch_pkg::module_kind_type kind_r [NUM_MOD];
    logic [ASM_W-1:0] asm_r [NUM_MOD];
    logic [OFF_W-1:0] off_r [NUM_MOD];
    logic [7:0]       len_r [NUM_MOD];
    logic [NUM_MOD-1:0] pend_r;
    logic [NUM_ASM-1:0] recv_r;
    logic               cmdPend_r;
    logic               started_r;
    logic [11:0]        fbTotal_r;
    disp_state_type     state_r;
    logic [OFF_W-1:0]   ptr_r;
    logic [7:0]         cnt_r;
    logic               rxTake;
    logic               rxDone;
    logic [NUM_ASM-1:0] usedMask;
    logic               allRecv;
    logic               lenOk;
    logic               fitOk;
    logic               cmdOk;
    logic [11:0]        fbNxt;
    logic               cfgOk;
    logic               pickFound;
    logic [MOD_W-1:0]   pick;
    logic               sendDone;

    function automatic logic [ASM_W+OFF_W-1:0] imgAddr(input logic [ASM_W-1:0] a,
                                                        input logic [OFF_W-1:0] o);
        imgAddr = {a, o};
    endfunction

    // writes from an assembly without an open connection are dropped
    assign rxTake = rxValid && connOpen[rxAsm];
    assign rxDone = rxEnd && connOpen[rxAsm];

    // ------------------------------------------------------------
    // slot checks
    // ------------------------------------------------------------
    always_comb
    begin
        case (cfgKind)
            island_dispatch_pkg::KIND_DISCRETE:
                lenOk = cfgLen == 8'(island_dispatch_pkg::DISCRETE_BYTES);
            island_dispatch_pkg::KIND_ANALOG:
                lenOk = cfgLen == 8'(island_dispatch_pkg::ANALOG_CHANNELS *
                                     island_dispatch_pkg::CHANNEL_BYTES);
            island_dispatch_pkg::KIND_FIELDBUS:
                lenOk = (cfgLen != 8'h00) &&
                        (cfgLen <= 8'(island_dispatch_pkg::FD_MAX_BYTES));
            default:
                lenOk = 1'b1;
        endcase
        fitOk = ({1'b0, cfgOffset} + {{(OFF_W-7){1'b0}}, cfgLen}) <=
                (OFF_W+1)'(ASM_BYTES);
        cmdOk = !((cfgAsm == '0) && (cfgOffset < OFF_W'(island_dispatch_pkg::CMD_BYTES)) &&
                  (cfgKind != island_dispatch_pkg::KIND_NONE));
        fbNxt = fbTotal_r;
        if (kind_r[cfgIndex] == island_dispatch_pkg::KIND_FIELDBUS)
            fbNxt = fbNxt - {4'h0, len_r[cfgIndex]};
        if (cfgKind == island_dispatch_pkg::KIND_FIELDBUS)
            fbNxt = fbNxt + {4'h0, cfgLen};
        cfgOk = lenOk && fitOk && cmdOk &&
                (fbNxt <= 12'(island_dispatch_pkg::FB_SUM_BYTES));
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < NUM_MOD; i++)
            begin
                kind_r[i] <= island_dispatch_pkg::KIND_NONE;
                asm_r[i]  <= '0;
                off_r[i]  <= '0;
                len_r[i]  <= 8'h00;
            end
            fbTotal_r <= 12'h000;
            cfgError   <= 1'b0;
        end
        else
        begin
            cfgError <= cfgWrite && !cfgOk;
            if (cfgWrite && cfgOk)
            begin
                kind_r[cfgIndex] <= cfgKind;
                asm_r[cfgIndex]  <= cfgAsm;
                off_r[cfgIndex]  <= cfgOffset;
                len_r[cfgIndex]  <= cfgLen;
                fbTotal_r        <= fbNxt;
            end
        end
    end

    // ------------------------------------------------------------
    // image store and arrival tracking
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rxTake)
            image[imgAddr(rxAsm, rxOffset)] <= rxData;
    end

    always_comb
    begin
        usedMask = '0;
        usedMask[0] = 1'b1;
        for (int i = 0; i < NUM_MOD; i++)
            if (kind_r[i] != island_dispatch_pkg::KIND_NONE)
                usedMask[asm_r[i]] = 1'b1;
        allRecv = &(recv_r | ~usedMask);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            recv_r    <= '0;
            started_r <= 1'b0;
        end
        else
        begin
            if (rxDone)
                recv_r[rxAsm] <= 1'b1;
            if (allRecv)
                started_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // pending updates; a new arrival wins over a finishing send
    // ------------------------------------------------------------
    assign sendDone = (state_r == ST_SEND) && (cnt_r == 8'h00) && (!islValid || islReady);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pend_r    <= '0;
            cmdPend_r <= 1'b0;
        end
        else
        begin
            if (state_r == ST_IDLE && cmdPend_r)
                cmdPend_r <= 1'b0;
            if (sendDone)
                pend_r[islModule] <= 1'b0;
            for (int i = 0; i < NUM_MOD; i++)
                if (kind_r[i] != island_dispatch_pkg::KIND_NONE &&
                    ((allRecv && !started_r) ||
                     (started_r && rxDone && asm_r[i] == rxAsm)))
                    pend_r[i] <= 1'b1;
            if ((allRecv && !started_r) || (started_r && rxDone && rxAsm == '0))
                cmdPend_r <= 1'b1;
        end
    end

    always_comb
    begin
        pickFound = 1'b0;
        pick      = '0;
        for (int i = NUM_MOD - 1; i >= 0; i--)
            if (pend_r[i])
            begin
                pickFound = 1'b1;
                pick      = MOD_W'(i);
            end
    end

    // ------------------------------------------------------------
    // dispatch; islData, islModule and islCommand hold their last value between updates
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r         <= ST_IDLE;
            ptr_r           <= '0;
            cnt_r           <= 8'h00;
            islModule       <= '0;
            islValid        <= 1'b0;
            islData         <= 8'h00;
            islLast         <= 1'b0;
            islCommand      <= 16'h0000;
            islCommandValid <= 1'b0;
        end
        else
        begin
            islCommandValid <= 1'b0;
            case (state_r)
                ST_IDLE:
                begin
                    if (cmdPend_r)
                    begin
                        // command register: low byte at the lower offset
                        islCommand      <= {image[imgAddr('0, OFF_W'(1))],
                                            image[imgAddr('0, '0)]};
                        islCommandValid <= 1'b1;
                    end
                    else if (pickFound)
                    begin
                        islModule <= pick;
                        ptr_r     <= off_r[pick];
                        cnt_r     <= len_r[pick];
                        state_r   <= ST_SEND;
                    end
                end
                ST_SEND:
                begin
                    if (!islValid || islReady)
                    begin
                        if (cnt_r != 8'h00)
                        begin
                            // ascending offsets give low byte then high byte
                            islData  <= image[imgAddr(asm_r[islModule], ptr_r)];
                            islValid <= 1'b1;
                            islLast  <= cnt_r == 8'h01;
                            ptr_r    <= ptr_r + 1'b1;
                            cnt_r    <= cnt_r - 8'h01;
                        end
                        else
                        begin
                            islValid <= 1'b0;
                            islLast  <= 1'b0;
                            state_r  <= ST_IDLE;
                        end
                    end
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    assign islStarted = started_r;
    assign fbTotal    = fbTotal_r;

    explicit_request_responder #(
        .RESP_CYCLES (RESP_CYCLES)
    ) responder (
        .clk          (clk),
        .rst          (rst),
        .reqValid     (reqValid),
        .reqReady     (reqReady),
        .reqUnit      (reqUnit),
        .reqFunc      (reqFunc),
        .rspValid     (rspValid),
        .rspAccept    (rspAccept),
        .rspException (rspException)
    );

    sequence cfgBadLen(island_dispatch_pkg::module_kind_type k, int n);
        cfgWrite && cfgKind == k && cfgLen != 8'(n);
    endsequence

    AST_NO_EARLY_DISPATCH: assert property (@(posedge clk) disable iff (rst)
        !started_r |-> !islValid && !islCommandValid)
        else $error("island driven before all assemblies arrived");
    AST_DISCRETE_LEN: assert property (@(posedge clk) disable iff (rst)
        cfgBadLen(island_dispatch_pkg::KIND_DISCRETE, 2) |=> cfgError)
        else $error("bad discrete slot accepted");
    AST_ANALOG_LEN: assert property (@(posedge clk) disable iff (rst)
        cfgBadLen(island_dispatch_pkg::KIND_ANALOG, 4) |=> cfgError)
        else $error("bad analog slot accepted");
    AST_NO_SPLIT: assert property (@(posedge clk) disable iff (rst)
        cfgWrite && !fitOk |=> cfgError && $stable(fbTotal_r))
        else $error("slot crossing assembly end accepted");
    AST_FB_SUM_LIMIT: assert property (@(posedge clk) disable iff (rst)
        fbTotal_r <= 12'(island_dispatch_pkg::FB_SUM_BYTES))
        else $error("fieldbus data total over limit");
    AST_FD_LIMIT: assert property (@(posedge clk) disable iff (rst)
        cfgWrite && cfgKind == island_dispatch_pkg::KIND_FIELDBUS && cfgLen > 8'hFA
        |=> cfgError)
        else $error("oversize fieldbus device accepted");
    AST_CMD_SLOT: assert property (@(posedge clk) disable iff (rst)
        cfgWrite && cfgAsm == '0 && cfgOffset < OFF_W'(2) &&
        cfgKind != island_dispatch_pkg::KIND_NONE |=> cfgError)
        else $error("module placed over command register");
    AST_START_SETS: assert property (@(posedge clk) disable iff (rst)
        allRecv && !started_r |=> started_r && cmdPend_r)
        else $error("start not taken when image complete");
    AST_SEND_PENDING: assert property (@(posedge clk) disable iff (rst)
        state_r == ST_IDLE && !cmdPend_r && pickFound ##1 state_r == ST_SEND
        |-> $past(pend_r[pick]))
        else $error("module sent without update");
    AST_HOLD: assert property (@(posedge clk) disable iff (rst)
        state_r == ST_IDLE |=> $stable(islData))
        else $error("output data changed without update");
endmodule

// [include/island_dispatch_pkg.sv]
/*
 * constants, kinds and timing shared by the output image dispatcher and its
 * explicit request responder. assumes a single 100 MHz clock.
 */
package island_dispatch_pkg;

    typedef enum logic [1:0] {KIND_NONE, KIND_DISCRETE, KIND_ANALOG, KIND_FIELDBUS}
        module_kind_type;

    // output image layout
    localparam int CMD_BYTES       = 2;
    localparam int DISCRETE_BYTES  = 2;
    localparam int ANALOG_CHANNELS = 2;
    localparam int CHANNEL_BYTES   = 2;
    localparam int FB_SUM_BYTES    = 1024;
    localparam int FD_MAX_BYTES    = 250;

    // explicit request decoding
    localparam logic [7:0] FC_READ_MULTI  = 8'h03;
    localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
    localparam logic [7:0] FC_READ_WRITE  = 8'h17;
    localparam logic [7:0] UNIT_SELF_HIGH = 8'hFF;
    localparam logic [7:0] UNIT_SELF_ZERO = 8'h00;
    localparam logic [7:0] EXC_NONE       = 8'h00;
    localparam logic [7:0] EXC_ILLEGAL_FN = 8'h01;

    // timing
    localparam int CLK_HZ       = 100_000_000;
    localparam int RESP_TIME_MS = 200;
    localparam int RESP_CYCLES  = RESP_TIME_MS * (CLK_HZ / 1000);

endpackage

// [tb/island_bus_model.sv]
/*
 * island bus partner: accepts module bytes and records them per slot.
 * assumes islValid/islData/islLast held until accepted.
 */
`timescale 1ns/10ps
module island_bus_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // mode: slow accepts only every other cycle
    input  wire logic       slow,
    // island bus
    input  wire logic       islValid,
    input  wire logic       islLast,
    input  wire logic [2:0] islModule,
    input  wire logic [7:0] islData,
    output logic            islReady,
    output int              frames
);
    logic [7:0] seen [8][256];
    logic [7:0] idx;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst) islReady <= 1'b0;
        else islReady <= slow ? ~islReady : 1'b1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            idx    <= 8'h00;
            frames <= 0;
        end
        else if (islValid && islReady)
        begin
            seen[islModule][idx] <= islData;
            idx <= islLast ? 8'h00 : idx + 8'h01;
            if (islLast) frames <= frames + 1;
        end
    end
endmodule

// [tb/island_output_image_dispatch_tb_top.sv]
/*
 * self-checking bench for the output image dispatcher.
 * assumes the island bus model beside it and a short response count.
 */
`timescale 1ns/10ps
module island_output_image_dispatch_tb_top;
    localparam int RESP = 8;
    logic clk, rst, rxValid, rxEnd, cfgWrite, cfgError, islStarted, islCommandValid, slow;
    logic islValid, islReady, islLast, reqValid, reqReady, rspValid, rspAccept, rxAsm, cfgAsm;
    logic [1:0] connOpen;
    logic [8:0] rxOffset, cfgOffset;
    logic [7:0] rxData, cfgLen, islData, reqUnit, reqFunc, rspException;
    logic [2:0] cfgIndex, islModule;
    logic [11:0] fbTotal;
    logic [15:0] islCommand;
    island_dispatch_pkg::module_kind_type cfgKind;
    int failures, checked;

    island_output_image_dispatch #(.RESP_CYCLES(RESP)) i_dut (.clk(clk), .rst(rst),
        .connOpen(connOpen), .rxValid(rxValid), .rxAsm(rxAsm), .rxOffset(rxOffset),
        .rxData(rxData), .rxEnd(rxEnd), .cfgWrite(cfgWrite), .cfgIndex(cfgIndex),
        .cfgKind(cfgKind), .cfgAsm(cfgAsm), .cfgOffset(cfgOffset), .cfgLen(cfgLen),
        .cfgError(cfgError), .fbTotal(fbTotal), .islStarted(islStarted),
        .islCommandValid(islCommandValid), .islCommand(islCommand), .islValid(islValid),
        .islReady(islReady), .islModule(islModule), .islData(islData), .islLast(islLast),
        .reqValid(reqValid), .reqReady(reqReady), .reqUnit(reqUnit), .reqFunc(reqFunc),
        .rspValid(rspValid), .rspAccept(rspAccept), .rspException(rspException));
    island_bus_model i_model (.clk(clk), .rst(rst), .slow(slow), .islValid(islValid),
        .islLast(islLast), .islModule(islModule), .islData(islData), .islReady(islReady),
        .frames());

    //------------------------------------------------------------
    // helpers
    //------------------------------------------------------------
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done;
        if (failures == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    function automatic logic [7:0] pat(logic a, int off);
        return off[7:0] ^ {a, 7'h00};
    endfunction

    task automatic cfg(int i, island_dispatch_pkg::module_kind_type k, logic a, int off,
                       int len, logic err);
        @(posedge clk);
        cfgWrite <= 1'b1; cfgIndex <= i[2:0]; cfgKind <= k; cfgAsm <= a;
        cfgOffset <= off[8:0]; cfgLen <= len[7:0];
        @(posedge clk);
        cfgWrite <= 1'b0;
        #1 check("cfgError", 16'(err), 16'(cfgError));
    endtask

    task automatic wr(logic a, int off, logic [7:0] d, logic last);
        @(posedge clk);
        rxValid <= 1'b1; rxAsm <= a; rxOffset <= off[8:0]; rxData <= d; rxEnd <= last;
        @(posedge clk);
        rxValid <= 1'b0; rxEnd <= 1'b0;
    endtask

    task automatic fill(logic a);
        for (int i = 0; i < 512; i++) wr(a, i, pat(a, i), i == 511);
    endtask

    // bounded wait on completed island frames
    task automatic frames_wait(int n);
        for (int i = 0; i < 8000 && i_model.frames < n; i++) @(posedge clk);
        if (i_model.frames < n) begin failures++; test_done(); end
    endtask

    //------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------
    task automatic cfg_rules;
        cfg(7, island_dispatch_pkg::KIND_DISCRETE, 0, 2, 3, 1);
        cfg(7, island_dispatch_pkg::KIND_ANALOG, 0, 4, 2, 1);
        cfg(7, island_dispatch_pkg::KIND_DISCRETE, 1, 511, 2, 1);
        cfg(7, island_dispatch_pkg::KIND_DISCRETE, 0, 0, 2, 1);
        cfg(7, island_dispatch_pkg::KIND_FIELDBUS, 1, 0, 251, 1);
        cfg(0, island_dispatch_pkg::KIND_DISCRETE, 0, 2, 2, 0);
        cfg(1, island_dispatch_pkg::KIND_ANALOG, 0, 4, 4, 0);
        for (int k = 0; k < 4; k++)
            cfg(2 + k, island_dispatch_pkg::KIND_FIELDBUS, k < 2,
                k < 2 ? k * 250 : 8 + (k - 2) * 250, 250, 0);
        cfg(6, island_dispatch_pkg::KIND_FIELDBUS, 1, 500, 12, 0);
        cfg(7, island_dispatch_pkg::KIND_FIELDBUS, 1, 0, 13, 1);
        check("fbTotal", 16'h03F4, 16'(fbTotal));
    endtask

    task automatic start_rules;
        int i;
        fill(1);
        fill(0);
        repeat (5) @(posedge clk);
        #1 check("islStarted", 16'h0000, 16'(islStarted));
        connOpen <= 2'b11;
        fill(1);
        for (i = 0; i < 50 && islCommandValid !== 1'b1; i++) begin @(posedge clk); #1; end
        if (i == 50) begin failures++; test_done(); end
        check("islCommand", 16'h0100, islCommand);
        check("islStarted", 16'h0001, 16'(islStarted));
        frames_wait(7);
        check("discrete", {pat(0, 3), pat(0, 2)}, {i_model.seen[0][1], i_model.seen[0][0]});
        check("analog0", {pat(0, 5), pat(0, 4)}, {i_model.seen[1][1], i_model.seen[1][0]});
        check("analog1", {pat(0, 7), pat(0, 6)}, {i_model.seen[1][3], i_model.seen[1][2]});
        check("fieldbus", 16'(pat(1, 249)), 16'(i_model.seen[2][249]));
    endtask

    task automatic update_rules;
        int f;
        f = i_model.frames;
        wr(0, 2, 8'hA5, 0);
        repeat (20) @(posedge clk);
        check("held", 16'(pat(0, 2)), 16'(i_model.seen[0][0]));
        check("frames", 16'(f), 16'(i_model.frames));
        wr(0, 3, 8'h3C, 1);
        frames_wait(f + 4);
        check("updated", 16'h3CA5, {i_model.seen[0][1], i_model.seen[0][0]});
        f = i_model.frames;
        wr(1, 0, 8'h5A, 1);
        frames_wait(f + 3);
        check("fieldbusUpd", 16'h005A, 16'(i_model.seen[2][0]));
    endtask

    task automatic explicit_rules;
        logic [7:0] u [5] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'h11};
        logic [7:0] fc [5] = '{8'h03, 8'h10, 8'h17, 8'h2B, 8'h03};
        int n;
        for (int k = 0; k < 5; k++)
        begin
            @(posedge clk);
            reqValid <= 1'b1; reqUnit <= u[k]; reqFunc <= fc[k];
            @(posedge clk);
            reqValid <= 1'b0;
            #1 check("reqReady", 16'(k == 4), 16'(reqReady));
            for (n = 1; n <= RESP + 4; n++) begin @(posedge clk); #1; if (rspValid) break; end
            check("rspDelay", 16'(k < 4 ? RESP : RESP + 5), 16'(n));
            if (k < 4) check("rspAccept", 16'(k < 3), 16'(rspAccept));
            if (k < 4) check("rspException", 16'(k < 3 ? 0 : 1), 16'(rspException));
        end
    endtask

    //------------------------------------------------------------
    // clock, reset and sequence
    //------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        rst = 1'b1; rxValid = 1'b0; rxEnd = 1'b0; cfgWrite = 1'b0; reqValid = 1'b0;
        connOpen = 2'b01; rxAsm = 1'b0; rxOffset = 9'h000; rxData = 8'h00; cfgIndex = 3'h0;
        cfgKind = island_dispatch_pkg::KIND_NONE; cfgAsm = 1'b0; cfgOffset = 9'h000;
        cfgLen = 8'h00; reqUnit = 8'h00; reqFunc = 8'h00; slow = 1'b1;
        failures = 0; checked = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        cfg_rules();
        start_rules();
        slow <= 1'b0;
        update_rules();
        explicit_rules();
        test_done();
    end
endmodule
